// File: hdl/gpde_top.sv
// How it works
// - Port D has eight pins, each with its own direction.
// - Direction bit 1 turns the port D driver off, pin is input.
// - Direction bit 0 drives the port D latch bit onto the pin.
// - Reading the port D latch returns the latch, not the pins.
// - Power-on reset puts every port D direction bit at 1.
// - Small build leaves port D registers out; they read zero.
// - Large build gives port E four bits, three with direction.
// - Low port E pins selected as analog read as zero.
// - Port E direction uses the same 1 input, 0 output convention.
// - Analog selection never forces the port E drivers off.
// - Reading the port E latch returns the latched values.
// - Fourth port E pin is input only; config bit 0 means port.
// - Fourth port E pin has no direction or latch bit.
// - With config bit set, fourth pin is the master-clear input.
// - Programming-voltage detection comes from its own input, not the fourth pin.
// - Power-on reset puts the low port E pins in analog mode.
// - Fourth pin data reads zero while master-clear is enabled.
`timescale 1ns/100ps
`default_nettype none
`include "gpde_defs.svh"

module gpde_top
    import gpde_pkg::*;
#(
    parameter bit BUILD_40_PIN = 1'b1,
    parameter int D_WIDTH      = 8,
    parameter int E_LOW_WIDTH  = 3
) (
    input  wire logic                     clock,
    input  wire logic                     sys_rst,
    input  wire logic                     ce,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [`GPDE_ADDR_W-1:0]  paddr,
    input  wire logic [31:0]              pwdata,
    output var  logic [31:0]              prdata,
    output var  logic                     pready,
    output var  logic                     pslverr,
    input  wire logic [D_WIDTH-1:0]       port_d_pin_in,
    output var  logic [D_WIDTH-1:0]       port_d_pin_out,
    output var  logic [D_WIDTH-1:0]       port_d_pin_oe,
    input  wire logic [E_LOW_WIDTH-1:0]   port_e_low_pins_in,
    output var  logic [E_LOW_WIDTH-1:0]   port_e_low_pins_out,
    output var  logic [E_LOW_WIDTH-1:0]   port_e_low_pins_oe,
    output var  logic [E_LOW_WIDTH-1:0]   port_e_analog,
    input  wire logic                     port_e_input_only_pin,
    input  wire logic                     master_clear_enable_cfg,
    input  wire logic                     prog_voltage_in,
    output var  logic                     master_clear_rst,
    output var  logic                     prog_voltage_det
);

    localparam int SYNC_W = D_WIDTH + E_LOW_WIDTH + 3;
    localparam int E_ONLY = D_WIDTH + E_LOW_WIDTH;

    logic [SYNC_W-1:0]      sync_q;
    logic [D_WIDTH-1:0]     d_pins;
    logic [E_LOW_WIDTH-1:0] e_low;
    logic                   e_only;
    logic                   mclr_en;
    logic                   vpp_seen;
    logic [D_WIDTH-1:0]     d_dir;
    logic [E_LOW_WIDTH-1:0] e_dir;
    gpde_phase_type         phase;
    logic                   setup;
    logic                   access;
    logic                   wr_d_lat;
    logic                   wr_d_dir;
    logic                   wr_e_lat;
    logic                   wr_e_dir;
    logic                   wr_e_ana;
    logic                   unmapped;
    logic [3:0]             e_read;
    gpde_word_type          next_prdata;

    // Every pin and strap crosses in through two flops
    gpde_sync #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .ce       (ce),
        .async_in ({prog_voltage_in, master_clear_enable_cfg,
                    port_e_input_only_pin, port_e_low_pins_in, port_d_pin_in}),
        .sync_out (sync_q)
    );

    assign d_pins   = sync_q[D_WIDTH-1:0];
    assign e_low    = sync_q[D_WIDTH +: E_LOW_WIDTH];
    assign e_only   = sync_q[E_ONLY];
    assign mclr_en  = sync_q[E_ONLY+1];
    assign vpp_seen = sync_q[E_ONLY+2];

    assign setup  = psel && !penable && phase == GPDE_IDLE;
    assign access = psel && penable && pready;

    // Pin data writes land in the latch, as on the latch register itself
    always_comb begin
        wr_d_lat = 1'b0;
        wr_d_dir = 1'b0;
        wr_e_lat = 1'b0;
        wr_e_dir = 1'b0;
        wr_e_ana = 1'b0;
        if (access && pwrite) begin
            if (paddr == `GPDE_OFS_D_DATA || paddr == `GPDE_OFS_D_LATCH) begin
                wr_d_lat = 1'b1;
            end else if (paddr == `GPDE_OFS_D_DIR) begin
                wr_d_dir = 1'b1;
            end else if (paddr == `GPDE_OFS_E_DATA || paddr == `GPDE_OFS_E_LATCH) begin
                wr_e_lat = 1'b1;
            end else if (paddr == `GPDE_OFS_E_DIR) begin
                wr_e_dir = 1'b1;
            end else if (paddr == `GPDE_OFS_E_ANALOG) begin
                wr_e_ana = 1'b1;
            end
        end
    end

    gpde_pin_bank #(
        .WIDTH   (D_WIDTH),
        .PRESENT (BUILD_40_PIN),
        .RST_DIR (`GPDE_RST_D_DIR),
        .RST_LAT (`GPDE_RST_D_LATCH)
    ) u_port_d (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .ce       (ce),
        .wr_latch (wr_d_lat),
        .wr_dir   (wr_d_dir),
        .wdata    (pwdata[D_WIDTH-1:0]),
        .latch    (port_d_pin_out),
        .dir      (d_dir),
        .oe       (port_d_pin_oe)
    );

    // Analog select is kept out of the driver path on purpose
    gpde_pin_bank #(
        .WIDTH   (E_LOW_WIDTH),
        .PRESENT (BUILD_40_PIN),
        .RST_DIR (`GPDE_RST_E_DIR),
        .RST_LAT (`GPDE_RST_E_LATCH)
    ) u_port_e (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .ce       (ce),
        .wr_latch (wr_e_lat),
        .wr_dir   (wr_e_dir),
        .wdata    (pwdata[E_LOW_WIDTH-1:0]),
        .latch    (port_e_low_pins_out),
        .dir      (e_dir),
        .oe       (port_e_low_pins_oe)
    );

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            port_e_analog <= `GPDE_RST_E_ANALOG;
        end else if (ce && BUILD_40_PIN && wr_e_ana) begin
            port_e_analog <= pwdata[E_LOW_WIDTH-1:0];
        end
    end

    // Pin is active low as a reset; request held while the level lasts
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            master_clear_rst <= 1'b0;
        end else if (ce) begin
            master_clear_rst <= mclr_en && !e_only;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            prog_voltage_det <= 1'b0;
        end else if (ce) begin
            prog_voltage_det <= vpp_seen;
        end
    end

    // Fourth pin has data only, never latch or direction
    always_comb begin
        e_read = 4'h0;
        if (BUILD_40_PIN) begin
            e_read[E_LOW_WIDTH-1:0] = e_low & ~port_e_analog;
        end
        e_read[`GPDE_E_ONLY_BIT] = mclr_en ? 1'b0 : e_only;
    end

    always_comb begin
        next_prdata = 32'h0000_0000;
        unmapped    = 1'b0;
        if (paddr == `GPDE_OFS_D_DATA) begin
            next_prdata[D_WIDTH-1:0] = BUILD_40_PIN ? d_pins : '0;
        end else if (paddr == `GPDE_OFS_D_LATCH) begin
            next_prdata[D_WIDTH-1:0] = port_d_pin_out;
        end else if (paddr == `GPDE_OFS_D_DIR) begin
            next_prdata[D_WIDTH-1:0] = BUILD_40_PIN ? d_dir : '0;
        end else if (paddr == `GPDE_OFS_E_DATA) begin
            next_prdata[3:0] = e_read;
        end else if (paddr == `GPDE_OFS_E_LATCH) begin
            next_prdata[E_LOW_WIDTH-1:0] = port_e_low_pins_out;
        end else if (paddr == `GPDE_OFS_E_DIR) begin
            next_prdata[E_LOW_WIDTH-1:0] = BUILD_40_PIN ? e_dir : '0;
        end else if (paddr == `GPDE_OFS_E_ANALOG) begin
            next_prdata[E_LOW_WIDTH-1:0] = BUILD_40_PIN ? port_e_analog : '0;
        end else if (paddr == `GPDE_OFS_STATUS) begin
            next_prdata[`GPDE_ST_MCLR_BIT]   = mclr_en;
            next_prdata[`GPDE_ST_VPP_BIT]    = vpp_seen;
            next_prdata[`GPDE_ST_BUILD_BIT]  = BUILD_40_PIN;
            next_prdata[`GPDE_ST_RSTREQ_BIT] = master_clear_rst;
        end else begin
            unmapped = 1'b1;
        end
    end

    // Decoding at setup lets prdata, pready and pslverr all come from flops with no wait state
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            phase <= GPDE_IDLE;
        end else if (ce) begin
            case (phase)
                GPDE_IDLE: begin
                    if (setup) begin
                        phase <= GPDE_ACCESS;
                    end
                end
                GPDE_ACCESS: begin
                    // Ready lasts one enabled cycle, so an aborted transfer cannot lock us
                    phase <= GPDE_IDLE;
                end
                default: begin
                    phase <= GPDE_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready  <= setup;
            pslverr <= setup && unmapped;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
        end else if (ce && setup) begin
            prdata <= pwrite ? 32'h0000_0000 : next_prdata;
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    d_dir_drive_a:
    assert property (ce && wr_d_dir && BUILD_40_PIN
                     |=> port_d_pin_oe == ~$past(pwdata[D_WIDTH-1:0]))
    else $error("Port D enable does not follow direction write");

    d_latch_out_a:
    assert property (ce && wr_d_lat && BUILD_40_PIN
                     |=> port_d_pin_out == $past(pwdata[D_WIDTH-1:0]))
    else $error("Port D pins do not carry the written latch");

    d_latch_read_a:
    assert property (ce && setup && !pwrite && paddr == `GPDE_OFS_D_LATCH
                     |=> prdata[D_WIDTH-1:0] == $past(port_d_pin_out))
    else $error("Port D latch read does not return the latch");

    d_absent_a:
    assert property (!BUILD_40_PIN |-> port_d_pin_oe == '0 && d_dir == `GPDE_RST_D_DIR)
    else $error("Port D active in the small build");

    e_analog_zero_a:
    assert property (ce && setup && !pwrite && paddr == `GPDE_OFS_E_DATA
                     |=> (prdata[E_LOW_WIDTH-1:0] & $past(port_e_analog)) == '0)
    else $error("Analog port E pin reads non-zero");

    e_driver_kept_a:
    assert property (ce && wr_e_dir && BUILD_40_PIN
                     |=> port_e_low_pins_oe == ~$past(pwdata[E_LOW_WIDTH-1:0])
                         ##1 port_e_low_pins_oe == ~e_dir)
    else $error("Port E driver not under direction control");

    e_only_mclr_a:
    assert property (ce && setup && !pwrite && paddr == `GPDE_OFS_E_DATA && mclr_en
                     |=> prdata[`GPDE_E_ONLY_BIT] == 1'b0)
    else $error("Fourth pin reads non-zero with master-clear on");

    mclr_reset_a:
    assert property (ce && mclr_en && !e_only |=> master_clear_rst)
    else $error("Master-clear request missing");

    vpp_detect_a:
    assert property (ce ##1 ce |-> prog_voltage_det == $past(vpp_seen))
    else $error("Programming voltage detect does not follow the pin");

    apb_ready_a:
    assert property (ce && setup |=> pready)
    else $error("APB ready missing after setup");

    apb_single_a:
    assert property (ce && access |=> !pready)
    else $error("APB ready held past the access cycle");

    d_pin_read_a:
    assert property (ce && setup && !pwrite && paddr == `GPDE_OFS_D_DATA && BUILD_40_PIN
                     |=> prdata[D_WIDTH-1:0] == $past(d_pins))
    else $error("Port D data read does not return the pins");

    e_latch_out_a:
    assert property (ce && wr_e_lat && BUILD_40_PIN
                     |=> port_e_low_pins_out == $past(pwdata[E_LOW_WIDTH-1:0]))
    else $error("Port E pins do not carry the written latch");

    e_latch_read_a:
    assert property (ce && setup && !pwrite && paddr == `GPDE_OFS_E_LATCH
                     |=> prdata[E_LOW_WIDTH-1:0] == $past(port_e_low_pins_out))
    else $error("Port E latch read does not return the latch");

    e_no_fourth_a:
    assert property (ce && setup && !pwrite && paddr == `GPDE_OFS_E_LATCH
                     |=> prdata[`GPDE_E_ONLY_BIT] == 1'b0)
    else $error("Fourth pin shows a latch bit");

    e_analog_set_a:
    assert property (ce && wr_e_ana && BUILD_40_PIN
                     |=> port_e_analog == $past(pwdata[E_LOW_WIDTH-1:0]))
    else $error("Analog select does not follow its write");

    e_only_port_a:
    assert property (ce && setup && !pwrite && paddr == `GPDE_OFS_E_DATA && !mclr_en
                     |=> prdata[`GPDE_E_ONLY_BIT] == $past(e_only))
    else $error("Fourth pin data does not follow the pin");

    mclr_release_a:
    assert property (ce && !mclr_en |=> !master_clear_rst)
    else $error("Master-clear request while the pin is a port");

    cov_d_dir_write: cover property (ce && wr_d_dir);
    cov_e_analog_read: cover property (ce && access && !pwrite
                                       && paddr == `GPDE_OFS_E_DATA && port_e_analog != '0);
    cov_mclr_req: cover property (master_clear_rst);
    cov_unmapped: cover property (access && pslverr);
    cov_e_latch_write: cover property (ce && wr_e_lat);

endmodule

`default_nettype wire

// File: include/gpde_defs.svh
`ifndef GPDE_DEFS_SVH
`define GPDE_DEFS_SVH

`define GPDE_ADDR_W        8
`define GPDE_OFS_D_DATA    8'h00
`define GPDE_OFS_D_LATCH   8'h04
`define GPDE_OFS_D_DIR     8'h08
`define GPDE_OFS_E_DATA    8'h0C
`define GPDE_OFS_E_LATCH   8'h10
`define GPDE_OFS_E_DIR     8'h14
`define GPDE_OFS_E_ANALOG  8'h18
`define GPDE_OFS_STATUS    8'h1C

`define GPDE_RST_D_DIR     8'hFF
`define GPDE_RST_D_LATCH   8'h00
`define GPDE_RST_E_DIR     3'h7
`define GPDE_RST_E_LATCH   3'h0
`define GPDE_RST_E_ANALOG  3'h7

`define GPDE_E_ONLY_BIT    3
`define GPDE_ST_MCLR_BIT   0
`define GPDE_ST_VPP_BIT    1
`define GPDE_ST_BUILD_BIT  2
`define GPDE_ST_RSTREQ_BIT 3

`endif

// File: include/gpde_pkg.sv
package gpde_pkg;

    typedef enum logic [1:0] {
        GPDE_IDLE   = 2'b00,
        GPDE_ACCESS = 2'b01
    } gpde_phase_type;

    typedef logic [31:0] gpde_word_type;

endpackage

// File: hdl/gpde_sync.sv
`timescale 1ns/100ps
`default_nettype none

module gpde_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             clock,
    input  wire logic             sys_rst,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta;

    // First stage feeds only the second stage
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clock or posedge sys_rst) begin
            if (sys_rst) begin
                meta[i]     <= 1'b0;
                sync_out[i] <= 1'b0;
            end else if (ce) begin
                meta[i]     <= async_in[i];
                sync_out[i] <= meta[i];
            end
        end
    end

endmodule

`default_nettype wire

// File: hdl/gpde_pin_bank.sv
`timescale 1ns/100ps
`default_nettype none

module gpde_pin_bank #(
    parameter int               WIDTH   = 8,
    parameter bit               PRESENT = 1'b1,
    parameter logic [WIDTH-1:0] RST_DIR = '1,
    parameter logic [WIDTH-1:0] RST_LAT = '0
) (
    input  wire logic             clock,
    input  wire logic             sys_rst,
    input  wire logic             ce,
    input  wire logic             wr_latch,
    input  wire logic             wr_dir,
    input  wire logic [WIDTH-1:0] wdata,
    output var  logic [WIDTH-1:0] latch,
    output var  logic [WIDTH-1:0] dir,
    output var  logic [WIDTH-1:0] oe
);

    // Enable kept as its own flop so the pin driver is not behind an inverter
    for (genvar i = 0; i < WIDTH; i++) begin : g_pin
        always_ff @(posedge clock or posedge sys_rst) begin
            if (sys_rst) begin
                latch[i] <= RST_LAT[i];
                dir[i]   <= RST_DIR[i];
                oe[i]    <= ~RST_DIR[i];
            end else if (ce && PRESENT) begin
                if (wr_latch) begin
                    latch[i] <= wdata[i];
                end
                if (wr_dir) begin
                    dir[i] <= wdata[i];
                    oe[i]  <= ~wdata[i];
                end
            end
        end
    end

endmodule

`default_nettype wire

// File: verif/gpde_board.sv
`timescale 1ns/100ps
`default_nettype none

module gpde_board (
    input  wire logic [7:0] d_out,
    input  wire logic [7:0] d_oe,
    input  wire logic [7:0] d_drive,
    input  wire logic [2:0] e_out,
    input  wire logic [2:0] e_oe,
    input  wire logic [2:0] e_drive,
    output var  logic [7:0] d_pin,
    output var  logic [2:0] e_pin
);
    // Enabled device driver wins; board keepers drive released pins
    assign d_pin = (d_out & d_oe) | (d_drive & ~d_oe);
    assign e_pin = (e_out & e_oe) | (e_drive & ~e_oe);
endmodule

`default_nettype wire

// File: verif/gpde_top_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "gpde_defs.svh"

module gpde_top_test;
    logic        clock, sys_rst, psel, penable, pwrite, pready, pslverr;
    logic        cfg, fourth, vpp, mcr, vdet, ce;
    logic [7:0]  paddr, d_drive, d_pin, d_out, d_oe;
    logic [31:0] pwdata, prdata;
    logic [2:0]  e_drive, e_pin, e_out, e_oe, e_an;
    logic [32:0] expq[$];
    int          fails, total_checks;

    gpde_top DUT (.clock(clock), .sys_rst(sys_rst), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .port_d_pin_in(d_pin),
        .port_d_pin_out(d_out), .port_d_pin_oe(d_oe), .port_e_low_pins_in(e_pin),
        .port_e_low_pins_out(e_out), .port_e_low_pins_oe(e_oe), .port_e_analog(e_an),
        .port_e_input_only_pin(fourth), .master_clear_enable_cfg(cfg),
        .prog_voltage_in(vpp), .master_clear_rst(mcr), .prog_voltage_det(vdet));

    gpde_board board (.d_out(d_out), .d_oe(d_oe), .d_drive(d_drive), .e_out(e_out),
        .e_oe(e_oe), .e_drive(e_drive), .d_pin(d_pin), .e_pin(e_pin));

    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        $display("Checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Expectation is queued at setup; the monitor pops it when pready shows
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        expq.push_back(e);
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            fails++;
            close_out();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    always @(posedge clock) begin
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            chk({pslverr, prdata}, (expq.size() > 0) ? expq.pop_front() : 'x);
        end
    end

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    initial begin
        logic [7:0] l, m, b;
        logic [2:0] el, em, eb;
        void'($urandom(32'h9CD509CE));
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        d_drive = 8'hA5;
        e_drive = 3'h5;
        cfg = 1'b0;
        fourth = 1'b1;
        vpp = 1'b0;
        ce = 1'b1;
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
        @(negedge clock);
        chk({25'h0, d_oe}, 33'h0);
        chk({30'h0, e_an}, 33'h7);
        apb(1'b0, `GPDE_OFS_D_DIR, 32'h0, 33'hFF);
        apb(1'b0, `GPDE_OFS_D_LATCH, 32'h0, 33'h0);
        apb(1'b0, `GPDE_OFS_E_DIR, 32'h0, 33'h7);
        apb(1'b0, `GPDE_OFS_E_ANALOG, 32'h0, 33'h7);
        apb(1'b0, `GPDE_OFS_E_DATA, 32'h0, 33'h8);
        apb(1'b0, 8'h20, 32'h0, 33'h100000000);
        apb(1'b1, 8'h20, 32'hFF, 33'h100000000);
        apb(1'b1, `GPDE_OFS_STATUS, 32'hF, 33'h0);
        apb(1'b0, `GPDE_OFS_STATUS, 32'h0, 33'h4);
        for (int i = 0; i < 4; i++) begin
            l = 8'($urandom());
            m = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom());
            b = 8'($urandom());
            d_drive <= b;
            // Odd passes write the latch through the pin data offset
            apb(1'b1, i[0] ? `GPDE_OFS_D_DATA : `GPDE_OFS_D_LATCH, {24'h0, l}, 33'h0);
            apb(1'b1, `GPDE_OFS_D_DIR, {24'h0, m}, 33'h0);
            @(negedge clock);
            chk({25'h0, d_out}, {25'h0, l});
            chk({25'h0, d_oe}, {25'h0, ~m});
            repeat (3) @(posedge clock);
            apb(1'b0, `GPDE_OFS_D_DATA, 32'h0, {25'h0, (l & ~m) | (b & m)});
            apb(1'b0, `GPDE_OFS_D_LATCH, 32'h0, {25'h0, l});
        end
        apb(1'b1, `GPDE_OFS_E_ANALOG, 32'h0, 33'h0);
        for (int i = 0; i < 3; i++) begin
            el = 3'($urandom());
            em = (i == 0) ? 3'h0 : 3'($urandom());
            eb = 3'($urandom());
            e_drive <= eb;
            apb(1'b1, i[0] ? `GPDE_OFS_E_DATA : `GPDE_OFS_E_LATCH,
                {28'h0, 1'b1, el}, 33'h0);
            apb(1'b1, `GPDE_OFS_E_DIR, {29'h0, em}, 33'h0);
            @(negedge clock);
            chk({30'h0, e_out}, {30'h0, el});
            chk({30'h0, e_oe}, {30'h0, ~em});
            repeat (3) @(posedge clock);
            apb(1'b0, `GPDE_OFS_E_DATA, 32'h0,
                {29'h0, 1'b1, (el & ~em) | (eb & em)});
            apb(1'b0, `GPDE_OFS_E_LATCH, 32'h0, {30'h0, el});
        end
        // Deliberately analog with drivers on, to show the select never gates them
        apb(1'b1, `GPDE_OFS_E_ANALOG, 32'h7, 33'h0);
        @(negedge clock);
        chk({30'h0, e_oe}, {30'h0, ~em});
        chk({30'h0, e_an}, 33'h7);
        apb(1'b0, `GPDE_OFS_E_DATA, 32'h0, 33'h8);
        apb(1'b1, `GPDE_OFS_E_DIR, 32'h7, 33'h0);
        cfg <= 1'b1;
        fourth <= 1'b0;
        vpp <= 1'b1;
        repeat (5) @(posedge clock);
        chk({32'h0, mcr}, 33'h1);
        chk({32'h0, vdet}, 33'h1);
        apb(1'b0, `GPDE_OFS_E_DATA, 32'h0, 33'h0);
        apb(1'b0, `GPDE_OFS_STATUS, 32'h0, 33'hF);
        fourth <= 1'b1;
        repeat (5) @(posedge clock);
        chk({32'h0, mcr}, 33'h0);
        apb(1'b0, `GPDE_OFS_E_DATA, 32'h0, 33'h0);
        cfg <= 1'b0;
        fourth <= 1'b0;
        repeat (5) @(posedge clock);
        chk({32'h0, mcr}, 33'h0);
        chk({32'h0, vdet}, 33'h1);
        vpp <= 1'b0;
        repeat (5) @(posedge clock);
        chk({32'h0, vdet}, 33'h0);
        // Enable low must freeze the detector even though the pin rises
        ce <= 1'b0;
        vpp <= 1'b1;
        repeat (5) @(posedge clock);
        chk({32'h0, vdet}, 33'h0);
        ce <= 1'b1;
        repeat (5) @(posedge clock);
        chk({32'h0, vdet}, 33'h1);
        apb(1'b0, `GPDE_OFS_E_DATA, 32'h0, 33'h0);
        repeat (4) @(posedge clock);
        if (expq.size() != 0) begin
            fails++;
        end
        close_out();
    end
endmodule

`default_nettype wire
